/* common/hpm_pkg.sv */
package hpm_pkg;

    // ----------------------------------------------------------------
    // strap decoding
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        HPM_MODE_8080 = 3'h0,
        HPM_MODE_6800 = 3'h1,
        HPM_MODE_SPI3 = 3'h2,
        HPM_MODE_SPI4 = 3'h3,
        HPM_MODE_I2C  = 3'h4
    } hpm_mode_t;

    localparam logic [2:0] HPM_STRAP_RESET     = 3'h0;
    localparam int         HPM_STRAP_SETTLE    = 6;
    localparam logic [2:0] HPM_SETTLE_RESET    = 3'h0;

    // ----------------------------------------------------------------
    // pin field positions inside the synchroniser vector
    // ----------------------------------------------------------------
    localparam int HPM_SYNC_W      = 23;
    localparam int HPM_POS_DATA    = 0;
    localparam int HPM_POS_CS      = 16;
    localparam int HPM_POS_RD      = 17;
    localparam int HPM_POS_WR      = 18;
    localparam int HPM_POS_CD      = 19;
    localparam int HPM_POS_STRAP   = 20;
    // strobes idle high through the pull-ups; straps reset low
    localparam logic [22:0] HPM_SYNC_RESET = 23'h0f_0000;

    // ----------------------------------------------------------------
    // access sequencer
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        HPM_ST_IDLE     = 3'h0,
        HPM_ST_RD_WAIT  = 3'h1,
        HPM_ST_RD_DRIVE = 3'h3,
        HPM_ST_WR_STB   = 3'h4,
        HPM_ST_WR_WAIT  = 3'h5
    } hpm_state_t;

    // one access toward the core; req is a one-cycle pulse
    typedef struct packed {
        logic        req;
        logic        write;
        logic        cmd_data_sel;
        logic [15:0] wdata;
    } hpm_access_t;

    localparam hpm_access_t HPM_ACCESS_RESET = '{1'b0, 1'b0, 1'b0, 16'h0000};

    // serial-mode reuse of the control pins as general-purpose inputs
    typedef struct packed {
        logic cmd_data_sel;
        logic wr_dir;
        logic rd_en;
        logic cs_n;
    } hpm_ctl_pins_t;

endpackage

/* logic/hpm_host_port.sv */
`timescale 1ns/1ps
`default_nettype none

module hpm_host_port
    import hpm_pkg::*;
#(
    parameter int BUS_W = 16
) (
    input  wire logic          clk_sys,
    input  wire logic          rst_n,
    input  wire logic [2:0]    host_if_strap,
    input  wire logic          host_cs_n,
    input  wire logic          host_rd_en,
    input  wire logic          host_wr_dir,
    input  wire logic          cmd_data_sel,
    input  wire logic [15:0]   host_data_bus_i,
    output logic [15:0]        host_data_bus_o,
    output logic [15:0]        host_data_bus_oe,
    output logic               host_wait_n,
    output logic               host_int_n,
    input  wire logic          bus_16bit,
    output hpm_access_t        core_access,
    input  wire logic          core_ack,
    input  wire logic [15:0]   core_rdata,
    input  wire logic          core_int_req,
    output hpm_mode_t          host_mode,
    output logic               mode_valid,
    output logic               ext_int,
    output logic [7:0]         port_a_gpio_i,
    input  wire logic [7:0]    port_a_gpio_o,
    input  wire logic [7:0]    port_a_gpio_oe,
    output hpm_ctl_pins_t      port_b_gpio,
    output logic [7:0]         serial_pins_i,
    input  wire logic [7:0]    serial_pins_o,
    input  wire logic [7:0]    serial_pins_oe
);

    if (BUS_W != 16) begin : g_bad_width
        $error("hpm_host_port: only a 16-bit host data bus is supported");
    end

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic hpm_mode_t decode_strap(input logic [2:0] s);
        hpm_mode_t m;
        m = HPM_MODE_8080;
        if (s[2:1] == 2'b00) begin
            m = HPM_MODE_8080;
        end else if (s[2:1] == 2'b01) begin
            m = HPM_MODE_6800;
        end else if (s == 3'b100) begin
            m = HPM_MODE_SPI3;
        end else if (s == 3'b101) begin
            m = HPM_MODE_SPI4;
        end else begin
            m = HPM_MODE_I2C;
        end
        return m;
    endfunction

    function automatic logic is_parallel(input hpm_mode_t m);
        return (m == HPM_MODE_8080) || (m == HPM_MODE_6800);
    endfunction

    // ----------------------------------------------------------------
    // pin synchroniser: three stages, a bit moves once stages 2 and 3 agree
    // ----------------------------------------------------------------
    logic [HPM_SYNC_W-1:0] sync1;
    logic [HPM_SYNC_W-1:0] sync2;
    logic [HPM_SYNC_W-1:0] sync3;
    logic [HPM_SYNC_W-1:0] pins;
    wire  [HPM_SYNC_W-1:0] pin_raw;
    wire  [HPM_SYNC_W-1:0] agree;
    wire  [HPM_SYNC_W-1:0] next_pins;

    assign pin_raw   = {host_if_strap, cmd_data_sel, host_wr_dir, host_rd_en, host_cs_n,
                        host_data_bus_i};
    assign agree     = ~(sync2 ^ sync3);
    assign next_pins = (sync3 & agree) | (pins & ~agree);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sync1 <= HPM_SYNC_RESET;
            sync2 <= HPM_SYNC_RESET;
            sync3 <= HPM_SYNC_RESET;
            pins  <= HPM_SYNC_RESET;
        end else begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            sync3 <= sync2;
            pins  <= next_pins;
        end
    end

    wire [15:0] pin_data = pins[HPM_POS_DATA +: 16];
    wire        pin_cs_n = pins[HPM_POS_CS];
    wire        pin_rd   = pins[HPM_POS_RD];
    wire        pin_wr   = pins[HPM_POS_WR];
    wire        pin_cd   = pins[HPM_POS_CD];
    wire [2:0]  pin_strp = pins[HPM_POS_STRAP +: 3];

    // ----------------------------------------------------------------
    // strap capture after reset release, once the filter has settled
    // ----------------------------------------------------------------
    logic [2:0] settle_cnt;
    wire        settle_done = (settle_cnt == 3'(HPM_STRAP_SETTLE));

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            settle_cnt <= HPM_SETTLE_RESET;
            mode_valid <= 1'b0;
            host_mode  <= HPM_MODE_8080;
        end else if (!mode_valid) begin
            settle_cnt <= settle_cnt + 3'h1;
            if (settle_done) begin
                mode_valid <= 1'b1;
                host_mode  <= decode_strap(pin_strp);
            end
        end
    end

    // ----------------------------------------------------------------
    // strobe decode
    // ----------------------------------------------------------------
    wire par     = mode_valid && is_parallel(host_mode);
    wire m8080   = host_mode == HPM_MODE_8080;
    wire cs_ok   = par && !pin_cs_n;
    // 8080: separate active-low strobes; 6800: enable high, direction picks
    wire rd_act  = cs_ok && (m8080 ? !pin_rd : (pin_rd && pin_wr));
    wire wr_act  = cs_ok && (m8080 ? !pin_wr : (pin_rd && !pin_wr));
    wire wide    = bus_16bit && par;

    // ----------------------------------------------------------------
    // access sequencer
    // ----------------------------------------------------------------
    hpm_state_t  state;
    hpm_state_t  next_state;
    logic [15:0] rd_hold;
    logic [15:0] wr_hold;
    logic        cd_hold;

    always_comb begin
        next_state = state;
        case (state)
            HPM_ST_IDLE: begin
                if (rd_act) begin
                    next_state = HPM_ST_RD_WAIT;
                end else if (wr_act) begin
                    next_state = HPM_ST_WR_STB;
                end
            end
            HPM_ST_RD_WAIT: begin
                if (core_ack) begin
                    next_state = rd_act ? HPM_ST_RD_DRIVE : HPM_ST_IDLE;
                end
            end
            HPM_ST_RD_DRIVE: begin
                if (!rd_act) begin
                    next_state = HPM_ST_IDLE;
                end
            end
            HPM_ST_WR_STB: begin
                if (pin_cs_n) begin
                    next_state = HPM_ST_IDLE;
                end else if (!wr_act) begin
                    next_state = HPM_ST_WR_WAIT;
                end
            end
            HPM_ST_WR_WAIT: begin
                if (core_ack) begin
                    next_state = HPM_ST_IDLE;
                end
            end
            default: begin
                next_state = HPM_ST_IDLE;
            end
        endcase
    end

    wire start_rd = (state == HPM_ST_IDLE) && rd_act;
    wire end_wr   = (state == HPM_ST_WR_STB) && !pin_cs_n && !wr_act;
    wire take_rd  = (state == HPM_ST_RD_WAIT) && core_ack;
    wire [15:0] rd_word = wide ? core_rdata : {8'h00, core_rdata[7:0]};

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state   <= HPM_ST_IDLE;
            rd_hold <= 16'h0000;
            wr_hold <= 16'h0000;
            cd_hold <= 1'b0;
        end else begin
            state <= next_state;
            if (take_rd) begin
                rd_hold <= rd_word;
            end
            // keep sampling while the strobe is held so the last value wins
            if (next_state == HPM_ST_WR_STB && wr_act) begin
                wr_hold <= wide ? pin_data : {8'h00, pin_data[7:0]};
                cd_hold <= pin_cd;
            end
        end
    end

    // one request per host cycle, raised on entry to the wait state
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            core_access <= HPM_ACCESS_RESET;
        end else begin
            core_access.req <= start_rd || end_wr;
            if (start_rd) begin
                core_access.write        <= 1'b0;
                core_access.cmd_data_sel <= pin_cd;
            end else if (end_wr) begin
                core_access.write        <= 1'b1;
                core_access.cmd_data_sel <= cd_hold;
                core_access.wdata        <= wr_hold;
            end
        end
    end

    // ----------------------------------------------------------------
    // host-side outputs and pin sharing
    // ----------------------------------------------------------------
    wire        stall     = (next_state == HPM_ST_RD_WAIT) || (next_state == HPM_ST_WR_WAIT);
    wire        drive     = next_state == HPM_ST_RD_DRIVE;
    wire [7:0]  lo_oe     = par ? {8{drive}} : serial_pins_oe;
    wire [7:0]  lo_o      = par ? (take_rd ? rd_word[7:0] : rd_hold[7:0]) : serial_pins_o;
    wire [7:0]  hi_oe     = wide ? {8{drive}} : port_a_gpio_oe;
    wire [7:0]  hi_o      = wide ? (take_rd ? rd_word[15:8] : rd_hold[15:8]) : port_a_gpio_o;
    wire        serial    = mode_valid && !is_parallel(host_mode);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            host_data_bus_o  <= 16'h0000;
            host_data_bus_oe <= 16'h0000;
            host_wait_n      <= 1'b1;
            host_int_n       <= 1'b1;
            ext_int          <= 1'b0;
            port_a_gpio_i    <= 8'h00;
            port_b_gpio      <= '0;
            serial_pins_i    <= 8'h00;
        end else begin
            host_data_bus_o  <= {hi_o, lo_o};
            host_data_bus_oe <= {hi_oe, lo_oe};
            host_wait_n      <= !stall;
            host_int_n       <= !core_int_req;
            // the lowest strap bit is free once the parallel mode is known
            ext_int          <= par && pin_strp[0];
            port_a_gpio_i    <= wide ? 8'h00 : pin_data[15:8];
            port_b_gpio      <= serial ? {pin_cd, pin_wr, pin_rd, pin_cs_n} : '0;
            serial_pins_i    <= serial ? pin_data[7:0] : 8'h00;
        end
    end

endmodule

`default_nettype wire

/* bench/hpm_host_port_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module hpm_chk
    import hpm_pkg::*;
(
    input wire logic          clk_sys,
    input wire logic          rst_n,
    input wire logic          host_cs_n,
    input wire logic          core_ack,
    input wire logic [15:0]   core_rdata,
    input wire logic          core_int_req,
    input wire logic [15:0]   host_data_bus_o,
    input wire logic [15:0]   host_data_bus_oe,
    input wire logic          host_wait_n,
    input wire logic          host_int_n,
    input wire hpm_access_t   core_access,
    input wire hpm_mode_t     host_mode,
    input wire logic          mode_valid,
    input wire logic          ext_int,
    input wire hpm_ctl_pins_t port_b_gpio,
    input wire logic [7:0]    serial_pins_i
);
    wire par = host_mode == HPM_MODE_8080 || host_mode == HPM_MODE_6800;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_int; $past(rst_n) |-> host_int_n == !$past(core_int_req); endproperty
    a_int: assert property (p_int) else $error("int level wrong");
    property p_req; core_access.req |=> !core_access.req; endproperty
    a_req: assert property (p_req) else $error("access too long");
    property p_wreq; core_access.req |-> !host_wait_n; endproperty
    a_wreq: assert property (p_wreq) else $error("wait not low");
    property p_wack; core_ack && !host_wait_n |=> host_wait_n; endproperty
    a_wack: assert property (p_wack) else $error("wait stuck");
    property p_cs; host_cs_n [*8] |-> !core_access.req; endproperty
    a_cs: assert property (p_cs) else $error("access unselected");
    property p_mode; mode_valid |=> mode_valid && $stable(host_mode); endproperty
    a_mode: assert property (p_mode) else $error("mode moved");
    property p_ext; mode_valid && $past(mode_valid) && !par |-> !ext_int; endproperty
    a_ext: assert property (p_ext) else $error("ext int in serial");
    property p_pins;
        mode_valid && $past(mode_valid) && par |-> port_b_gpio == '0 && serial_pins_i == '0;
    endproperty
    a_pins: assert property (p_pins) else $error("serial pins live");
    property p_rd;
        core_ack && !host_wait_n && !core_access.write |=>
            (host_data_bus_o & host_data_bus_oe) == ($past(core_rdata) & host_data_bus_oe);
    endproperty
    a_rd: assert property (p_rd) else $error("read data wrong");
    property p_wr; core_access.req && core_access.write |-> host_data_bus_oe == '0; endproperty
    a_wr: assert property (p_wr) else $error("bus driven on write");
endmodule
bind hpm_host_port hpm_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .host_cs_n(host_cs_n),
    .core_ack(core_ack), .core_rdata(core_rdata), .core_int_req(core_int_req),
    .host_data_bus_o(host_data_bus_o), .host_data_bus_oe(host_data_bus_oe),
    .host_wait_n(host_wait_n), .host_int_n(host_int_n), .core_access(core_access),
    .host_mode(host_mode), .mode_valid(mode_valid), .ext_int(ext_int),
    .port_b_gpio(port_b_gpio), .serial_pins_i(serial_pins_i));
`default_nettype wire

/* bench/hpm_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module hpm_host_model (
    input  wire logic        clk_sys,
    input  wire logic        wait_n,
    input  wire logic [15:0] dev_o,
    input  wire logic [15:0] dev_oe,
    output logic             cs_n,
    output logic             rd_en,
    output logic             wr_dir,
    output logic             cd,
    output logic [15:0]      bus
);
    logic        m68 = 1'b0;
    logic        hoe = 1'b0;
    logic [15:0] hd  = 16'h0000;
    // an undriven bus shows the inverse of the last value, never a stale copy
    assign bus = (dev_oe & dev_o) | (~dev_oe & (hoe ? hd : ~hd));
    initial begin
        cs_n = 1'b1;
        rd_en = 1'b1;
        wr_dir = 1'b1;
        cd = 1'b1;
    end
    task automatic idle();
        cs_n = 1'b1;
        rd_en = !m68;
        wr_dir = 1'b1;
        hoe = 1'b0;
    endtask
    task automatic xfer(input logic wr, input logic c, input logic sel_n,
                        input logic [15:0] d, output logic [15:0] q);
        int n;
        @(posedge clk_sys);
        #1;
        cd = c;
        cs_n = sel_n;
        hd = d;
        hoe = wr;
        if (m68) begin
            wr_dir = !wr;
            rd_en = 1'b1;
        end else if (wr) begin
            wr_dir = 1'b0;
        end else begin
            rd_en = 1'b0;
        end
        repeat (wr ? 3 : 6) @(posedge clk_sys);
        #1;
        if (wr) begin
            if (m68) rd_en = 1'b0;
            else wr_dir = 1'b1;
            repeat (6) @(posedge clk_sys);
            #1;
        end
        n = 0;
        while (!wait_n && n < 64) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        q = bus;
        idle();
        repeat (6) @(posedge clk_sys);
        #1;
    endtask
endmodule
`default_nettype wire

/* bench/tb_host_port_mode_select_parallel.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_host_port_mode_select_parallel;
    import hpm_pkg::*;
    logic          clk_sys = 1'b0;
    logic          rst_n = 1'b0;
    logic [2:0]    strap = 3'h0;
    logic          bus_16bit = 1'b0;
    logic          core_ack = 1'b0;
    logic          core_int_req = 1'b0;
    logic [15:0]   core_rdata = 16'h0000;
    logic [15:0]   rd_val = 16'h0000;
    logic [15:0]   gp_o = 16'h0000;
    logic [15:0]   gp_oe = 16'h0000;
    logic [15:0]   exp_oe;
    wire logic     cs_n, rd_en, wr_dir, cd, wait_n, mode_valid, ext_int, int_n;
    wire logic [15:0] bus_i, d_o, d_oe;
    wire logic [7:0]  pa_i, sp_i;
    wire hpm_access_t acc;
    wire hpm_mode_t   mode;
    wire hpm_ctl_pins_t pb;
    hpm_access_t   exp_q[$];
    hpm_access_t   e;
    int            miscompares = 0;
    int            samples_checked = 0;
    int            cycles = 0;
    integer        seed = 32'hf21f;
    hpm_host_port u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .host_if_strap(strap),
        .host_cs_n(cs_n), .host_rd_en(rd_en), .host_wr_dir(wr_dir), .cmd_data_sel(cd),
        .host_data_bus_i(bus_i), .host_data_bus_o(d_o), .host_data_bus_oe(d_oe),
        .host_wait_n(wait_n), .host_int_n(int_n), .bus_16bit(bus_16bit), .core_access(acc),
        .core_ack(core_ack), .core_rdata(core_rdata), .core_int_req(core_int_req),
        .host_mode(mode), .mode_valid(mode_valid), .ext_int(ext_int), .port_a_gpio_i(pa_i),
        .port_a_gpio_o(gp_o[15:8]), .port_a_gpio_oe(gp_oe[15:8]), .port_b_gpio(pb),
        .serial_pins_i(sp_i), .serial_pins_o(gp_o[7:0]), .serial_pins_oe(gp_oe[7:0]));
    hpm_host_model u_host (.clk_sys(clk_sys), .wait_n(wait_n), .dev_o(d_o), .dev_oe(d_oe),
        .cs_n(cs_n), .rd_en(rd_en), .wr_dir(wr_dir), .cd(cd), .bus(bus_i));
    always #4 clk_sys = ~clk_sys;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    function automatic hpm_mode_t exp_mode(input logic [2:0] s);
        case (s[2:1])
            2'b00: return HPM_MODE_8080;
            2'b01: return HPM_MODE_6800;
            2'b10: return s[0] ? HPM_MODE_SPI4 : HPM_MODE_SPI3;
            default: return HPM_MODE_I2C;
        endcase
    endfunction
    task automatic op(input logic wr, input logic c, input logic sel_n);
        logic [15:0] d, q, m;
        d = 16'($random(seed));
        rd_val = 16'($random(seed));
        m = bus_16bit ? 16'hffff : 16'h00ff;
        if (!sel_n) exp_q.push_back('{1'b1, wr, c, d & m});
        u_host.xfer(wr, c, sel_n, d, q);
        if (!wr && !sel_n) check(q & m, rd_val & m);
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            conclude();
        end
    end
    // core side: answers each access after 0 to 2 idle cycles
    initial forever begin
        @(posedge clk_sys);
        #1;
        if (acc.req === 1'b1) begin
            repeat ($unsigned($random(seed)) % 3) @(posedge clk_sys);
            core_rdata = rd_val;
            core_ack = 1'b1;
            @(posedge clk_sys);
            #1;
            core_ack = 1'b0;
        end
    end
    initial forever begin
        @(posedge clk_sys);
        #1;
        if (acc.req === 1'b1) begin
            if (exp_q.size() == 0) check(1, 0);
            else begin
                e = exp_q.pop_front();
                check({acc.write, acc.cmd_data_sel, acc.write ? acc.wdata : 16'h0000},
                      {e.write, e.cmd_data_sel, e.write ? e.wdata : 16'h0000});
            end
        end
    end
    initial begin
        for (int s = 7; s >= 0; s--) begin
            @(posedge clk_sys);
            #1;
            strap = 3'(s);
            rst_n = 1'b0;
            core_int_req = 1'($random(seed));
            u_host.m68 = strap[2:1] == 2'b01;
            u_host.idle();
            repeat (10) @(posedge clk_sys);
            #1;
            rst_n = 1'b1;
            for (int n = 0; n < 40 && mode_valid !== 1'b1; n++) @(posedge clk_sys);
            #1;
            check(mode, exp_mode(strap));
            check(int_n, !core_int_req);
            bus_16bit = 1'b0;
            u_host.hd = 16'($random(seed));
            u_host.hoe = 1'b1;
            gp_o = 16'($random(seed));
            gp_oe = 16'($random(seed));
            if (strap[2]) {u_host.cd, u_host.wr_dir, u_host.rd_en, u_host.cs_n} = 4'($random(seed));
            repeat (6) @(posedge clk_sys);
            #1;
            check(pa_i, (gp_oe[15:8] & gp_o[15:8]) | (~gp_oe[15:8] & u_host.hd[15:8]));
            exp_oe = strap[2] ? gp_oe : {gp_oe[15:8], 8'h00};
            check({d_oe, d_o & d_oe}, {exp_oe, gp_o & exp_oe});
            if (strap[2]) begin
                check(pb, {u_host.cd, u_host.wr_dir, u_host.rd_en, u_host.cs_n});
                check(sp_i, (gp_oe[7:0] & gp_o[7:0]) | (~gp_oe[7:0] & u_host.hd[7:0]));
            end else begin
                check(ext_int, strap[0]);
                gp_oe = 16'h0000;
                u_host.idle();
                for (int w = 0; w < 2; w++) begin
                    bus_16bit = w[0];
                    op(1'b1, 1'b0, 1'b0);
                    op(1'b1, 1'b1, 1'b0);
                    op(1'b0, 1'b0, 1'b0);
                    op(1'b0, 1'b1, 1'b0);
                    op(1'b1, 1'b1, 1'b1);
                    op(1'b0, 1'b0, 1'b1);
                end
            end
            $display("strap %0d done", s);
        end
        conclude();
    end
endmodule
`default_nettype wire
